// ### quc_pkg.sv
// Shared constants, types and helper functions of the quadrature upconvert datapath
package quc_pkg;

  // Datapath widths
  localparam int NPROF = 4;
  localparam int CTW_W = 32;
  localparam int SAMP_W = 14;
  localparam int CAR_W = 16;
  localparam int MOD_W = 16;
  localparam int CORDIC_N = 14;

  // Byte register map
  localparam logic [4:0] ADDR_GLOBAL = 5'h01;
  localparam logic [4:0] ADDR_PHASE_MSB = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_PROF_BASE = 5'h07;
  localparam logic [4:0] PROF_STRIDE = 5'h06;
  localparam logic [4:0] CTW_OFS = 5'h01;
  localparam logic [4:0] SCALE_OFS = 5'h05;

  // Field positions
  localparam int CTRL_INVERT_BIT = 0;
  localparam int GLOBAL_SINC_BYPASS_BIT = 0;
  localparam int STATUS_SAT_BIT = 0;

  // Values after reset
  localparam logic [7:0] SCALE_RESET = 8'hB5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_RESET = 8'h01;
  localparam logic [31:0] CTW_RESET = 32'h0000_0000;

  // Arithmetic constants
  localparam logic [7:0] SCALE_UNITY = 8'h80;
  localparam int SCALE_SHIFT = 7;
  localparam int MIX_SHIFT = 15;
  localparam int SINC_SHIFT = 8;
  localparam logic signed [8:0] SINC_EDGE = -9'sh012;
  localparam logic signed [8:0] SINC_CENTER = 9'sh0D0;
  localparam logic signed [17:0] CORDIC_X0 = 18'sh04DB2;
  localparam logic [15:0] EIGHTH_TURN = 16'h2000;
  localparam logic signed [13:0] DAC_MAX = 14'sh1FFF;
  localparam logic signed [13:0] DAC_MIN = -14'sh2000;

  typedef logic signed [SAMP_W-1:0] quc_samp_t;
  typedef logic signed [MOD_W-1:0] quc_mod_t;

  // Clamp a wide signed value into the converter code range
  function automatic quc_samp_t quc_sat(input logic signed [24:0] v);
    if (v > 25'(DAC_MAX)) begin
      return DAC_MAX;
    end else if (v < 25'(DAC_MIN)) begin
      return DAC_MIN;
    end
    return v[SAMP_W-1:0];
  endfunction

  // Arctangent of 2^-i, 2^16 units per turn
  function automatic logic signed [16:0] quc_atan(input int i);
    case (i)
      0: return 17'sh02000;
      1: return 17'sh012E4;
      2: return 17'sh009FB;
      3: return 17'sh00511;
      4: return 17'sh0028B;
      5: return 17'sh00146;
      6: return 17'sh000A3;
      7: return 17'sh00051;
      8: return 17'sh00029;
      9: return 17'sh00014;
      10: return 17'sh0000A;
      11: return 17'sh00005;
      12: return 17'sh00003;
      default: return 17'sh00001;
    endcase
  endfunction

  // Base address of one profile's register block
  function automatic logic [4:0] quc_prof_base(input int p);
    return 5'(ADDR_PROF_BASE + p * PROF_STRIDE);
  endfunction

endpackage

// ### quc_carrier_if.sv
// Carrier synthesizer link: tuning word in, quadrature carrier out
`timescale 1ns/1ps
interface quc_carrier_if;
  logic [31:0] ctw; // Tuning word of the active profile
  logic signed [15:0] cosVal; // Carrier cosine
  logic signed [15:0] sinVal; // Carrier sine
  logic [31:0] phase; // Accumulator state
  modport synth (input ctw, output cosVal, output sinVal, output phase);
  modport user (output ctw, input cosVal, input sinVal, input phase);
endinterface

// ### quc_carrier_synth.sv
// Phase accumulator and pipelined CORDIC giving cosine and sine
`timescale 1ns/1ps
module quc_carrier_synth
  import quc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Carrier link
  quc_carrier_if.synth car
);

  logic [31:0] phase_r; // Phase accumulator
  logic [15:0] angle; // Top phase bits shifted by an eighth turn
  logic signed [17:0] xS [0:CORDIC_N]; // CORDIC x pipeline
  logic signed [17:0] yS [0:CORDIC_N]; // CORDIC y pipeline
  logic signed [16:0] zS [0:CORDIC_N]; // Residual angle pipeline
  logic [1:0] qS [0:CORDIC_N]; // Quadrant pipeline
  logic signed [15:0] cos_r; // Registered cosine
  logic signed [15:0] sin_r; // Registered sine

  // Accumulator wraps mod 2^32, so output frequency is ctw*fs/2^32
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= CTW_RESET;
    end else if (clkEn) begin
      phase_r <= phase_r + car.ctw;
    end
  end

  // Centring the residual keeps it within the CORDIC convergence range
  assign angle = phase_r[31:16] + EIGHTH_TURN;

  // Rotation pipeline, one micro-rotation per stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i <= CORDIC_N; i++) begin
        xS[i] <= '0;
        yS[i] <= '0;
        zS[i] <= '0;
        qS[i] <= '0;
      end
    end else if (clkEn) begin
      xS[0] <= CORDIC_X0;
      yS[0] <= '0;
      zS[0] <= $signed({3'b000, angle[13:0]}) - 17'sh02000;
      qS[0] <= angle[15:14];
      for (int i = 0; i < CORDIC_N; i++) begin
        qS[i+1] <= qS[i];
        if (zS[i] < 0) begin
          xS[i+1] <= xS[i] + (yS[i] >>> i);
          yS[i+1] <= yS[i] - (xS[i] >>> i);
          zS[i+1] <= zS[i] + quc_atan(i);
        end else begin
          xS[i+1] <= xS[i] - (yS[i] >>> i);
          yS[i+1] <= yS[i] + (xS[i] >>> i);
          zS[i+1] <= zS[i] - quc_atan(i);
        end
      end
    end
  end

  // Quadrant fold keeps cosine and sine a quarter cycle apart
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cos_r <= '0;
      sin_r <= '0;
    end else if (clkEn) begin
      unique case (qS[CORDIC_N])
        2'd0: begin
          cos_r <= 16'(xS[CORDIC_N]);
          sin_r <= 16'(yS[CORDIC_N]);
        end
        2'd1: begin
          cos_r <= 16'(-yS[CORDIC_N]);
          sin_r <= 16'(xS[CORDIC_N]);
        end
        2'd2: begin
          cos_r <= 16'(-xS[CORDIC_N]);
          sin_r <= 16'(-yS[CORDIC_N]);
        end
        2'd3: begin
          cos_r <= 16'(yS[CORDIC_N]);
          sin_r <= 16'(-xS[CORDIC_N]);
        end
      endcase
    end
  end

  assign car.cosVal = cos_r;
  assign car.sinVal = sin_r;
  assign car.phase = phase_r;

  chk_phase_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    clkEn |=> phase_r == $past(phase_r) + $past(car.ctw))
    else $error("phase did not advance by the tuning word");

endmodule // quc_carrier_synth

// ### quc_upconvert_datapath.sv
// Quadrature upconvert datapath: registers, mixer, inverse sinc, output scale
//
// How it works
// - Invert bit 1: I cos plus Q sin
// - Invert bit 0: I cos minus Q sin
// - Cosine feeds I, sine feeds Q, summed
// - Each profile holds own 32-bit tuning word
// - Carrier frequency is word times clock over 2^32
// - Profile one word lives at bytes 08h-0Bh
// - One modulated sample every sample clock
// - Optional FIR inverts converter sinc roll-off
// - Inverse sinc costs about 3.5 dB at dc
// - Bypassed inverse sinc passes samples, stage frozen
// - Per-profile 8-bit scale multiplies each sample
// - Scale is unsigned, LSB weight 2^-7
// - Every profile scale resets to B5h
// - Scale 80h bypasses the multiplier
// - Deliver 14-bit words, one per clock
`timescale 1ns/1ps
module quc_upconvert_datapath
  import quc_pkg::*;
(
  // Clock, reset and freeze
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Byte register port
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // Sample stream
  input wire logic [1:0] profileSel,
  input wire logic signed [13:0] iData,
  input wire logic signed [13:0] qData,
  // Converter feed
  output logic signed [13:0] dacData
);

  // Per-profile and global control
  logic [31:0] ctw_r [0:NPROF-1]; // Carrier tuning words
  logic [7:0] scale_r [0:NPROF-1]; // Output scale values
  logic [7:0] ctrl_r [0:NPROF-1]; // Profile control, bit 0 spectral invert
  logic [7:0] global_r; // Global control, bit 0 inverse sinc bypass
  logic [7:0] regRdData_r; // Registered read data
  logic sat_r; // Last sample was clamped

  // Datapath
  quc_carrier_if car (); // Carrier link
  logic spectralInv; // Invert bit of the active profile
  logic sincBypass; // Inverse sinc stage bypassed
  logic [7:0] activeScale; // Scale value of the active profile
  logic signed [29:0] prodI; // I times cosine
  logic signed [29:0] prodQ; // Q times sine
  logic signed [30:0] mixSum; // Sum or difference of products
  quc_mod_t mod_nxt; // Modulated sample before register
  quc_mod_t mod_r; // Modulated sample
  quc_mod_t sincTap_r [0:1]; // FIR delay line
  logic signed [26:0] firAcc; // FIR accumulator
  quc_mod_t fir_nxt; // FIR output or bypass value
  quc_mod_t fir_r; // Stage output to scaler
  logic signed [24:0] scaleProd; // Sample times scale
  logic signed [24:0] scaleShift; // Product at unit weight
  quc_samp_t dac_nxt; // Clamped converter word
  logic satNow; // Present result out of range
  quc_samp_t dac_r; // Converter word register
  logic [7:0] rd_nxt; // Read mux

  // Tuning word byte writes, lowest address holds the low byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NPROF; p++) begin
        ctw_r[p] <= CTW_RESET;
      end
    end else if (clkEn && regWrEn) begin
      for (int p = 0; p < NPROF; p++) begin
        for (int b = 0; b < 4; b++) begin
          // Profile one lands on 08h..0Bh
          if (regAddr == 5'(quc_prof_base(p) + CTW_OFS + b)) begin
            ctw_r[p][8*b +: 8] <= regWrData;
          end
        end
      end
    end
  end

  // Scale writes; reset value restores the modulator's 3 dB loss
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NPROF; p++) begin
        scale_r[p] <= SCALE_RESET;
      end
    end else if (clkEn && regWrEn) begin
      for (int p = 0; p < NPROF; p++) begin
        if (regAddr == 5'(quc_prof_base(p) + SCALE_OFS)) begin
          scale_r[p] <= regWrData;
        end
      end
    end
  end

  // Profile control writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NPROF; p++) begin
        ctrl_r[p] <= CTRL_RESET;
      end
    end else if (clkEn && regWrEn) begin
      for (int p = 0; p < NPROF; p++) begin
        if (regAddr == quc_prof_base(p)) begin
          ctrl_r[p] <= regWrData;
        end
      end
    end
  end

  // Global control write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      global_r <= GLOBAL_RESET;
    end else if (clkEn && regWrEn && regAddr == ADDR_GLOBAL) begin
      global_r <= regWrData;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (regAddr == ADDR_GLOBAL) begin
      rd_nxt = global_r;
    end else if (regAddr == ADDR_PHASE_MSB) begin
      rd_nxt = car.phase[31:24];
    end else if (regAddr == ADDR_STATUS) begin
      rd_nxt = 8'h00;
      rd_nxt[STATUS_SAT_BIT] = sat_r;
    end
    for (int p = 0; p < NPROF; p++) begin
      if (regAddr == quc_prof_base(p)) begin
        rd_nxt = ctrl_r[p];
      end
      if (regAddr == 5'(quc_prof_base(p) + SCALE_OFS)) begin
        rd_nxt = scale_r[p];
      end
      for (int b = 0; b < 4; b++) begin
        if (regAddr == 5'(quc_prof_base(p) + CTW_OFS + b)) begin
          rd_nxt = ctw_r[p][8*b +: 8];
        end
      end
    end
  end

  // Read data one cycle after the address
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdData_r <= 8'h00;
    end else if (clkEn) begin
      regRdData_r <= rd_nxt;
    end
  end
  assign regRdData = regRdData_r;

  // Active profile selection
  assign spectralInv = ctrl_r[profileSel][CTRL_INVERT_BIT];
  assign sincBypass = global_r[GLOBAL_SINC_BYPASS_BIT];
  assign activeScale = scale_r[profileSel];
  // Words above 2^31 alias past Nyquist; the host keeps them low
  assign car.ctw = ctw_r[profileSel];

  quc_carrier_synth u_synth (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clkEn(clkEn),
    .car(car)
  );

  // Mixer: cosine on I, sine on Q, sign from the invert bit
  always_comb begin
    prodI = iData * car.cosVal;
    prodQ = qData * car.sinVal;
    if (spectralInv) begin
      mixSum = 31'(prodI) + 31'(prodQ);
    end else begin
      mixSum = 31'(prodI) - 31'(prodQ);
    end
    mod_nxt = 16'(mixSum >>> MIX_SHIFT);
  end

  // One modulated sample per enabled clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mod_r <= '0;
    end else if (clkEn) begin
      mod_r <= mod_nxt;
    end
  end

  // Delay line only moves while the stage is in use, standing in for
  // the stopped clock; on re-entry the first two outputs use stale taps
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sincTap_r[0] <= '0;
      sincTap_r[1] <= '0;
    end else if (clkEn && !sincBypass) begin
      sincTap_r[0] <= mod_r;
      sincTap_r[1] <= sincTap_r[0];
    end
  end

  // Three-tap symmetric FIR: dc gain 172/256, boost near 45% of fs
  always_comb begin
    firAcc = 27'(SINC_EDGE * mod_r) + 27'(SINC_CENTER * sincTap_r[0])
      + 27'(SINC_EDGE * sincTap_r[1]);
    if (sincBypass) begin
      fir_nxt = mod_r;
    end else begin
      fir_nxt = 16'(firAcc >>> SINC_SHIFT);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fir_r <= '0;
    end else if (clkEn) begin
      fir_r <= fir_nxt;
    end
  end

  // Output scale: unsigned 1.7 multiplier, unity skips the multiply
  always_comb begin
    scaleProd = 25'(fir_r * $signed({1'b0, activeScale}));
    scaleShift = scaleProd >>> SCALE_SHIFT;
    if (activeScale == SCALE_UNITY) begin
      dac_nxt = quc_sat(25'(fir_r));
      satNow = (25'(fir_r) > 25'(DAC_MAX)) || (25'(fir_r) < 25'(DAC_MIN));
    end else begin
      dac_nxt = quc_sat(scaleShift);
      satNow = (scaleShift > 25'(DAC_MAX)) || (scaleShift < 25'(DAC_MIN));
    end
  end

  // Converter word and clamp status
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dac_r <= '0;
      sat_r <= 1'b0;
    end else if (clkEn) begin
      dac_r <= dac_nxt;
      sat_r <= satNow;
    end
  end
  assign dacData = dac_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Stage is in use and its input stays put for three cycles
  sequence sDcSettle;
    (clkEn && !sincBypass && $stable(mod_r)) [*3];
  endsequence

  // Unity scale with an in-range sample
  sequence sUnityInRange;
    clkEn && activeScale == SCALE_UNITY && fir_r <= 16'sh1FFF && fir_r >= -16'sh2000;
  endsequence

  chk_mix_plus: assert property (
    clkEn && spectralInv |=> mod_r == 16'(($past(prodI) + $past(prodQ)) >>> 15))
    else $error("inverted mix is not I cos plus Q sin");

  chk_mix_minus: assert property (
    clkEn && !spectralInv |=> mod_r == 16'(($past(prodI) - $past(prodQ)) >>> 15))
    else $error("normal mix is not I cos minus Q sin");

  chk_ctw_write: assert property (
    clkEn && regWrEn && regAddr == 5'h08 |=> ctw_r[0][7:0] == $past(regWrData))
    else $error("profile one tuning word low byte not written");

  chk_sinc_bypass: assert property (
    clkEn && sincBypass |=> fir_r == $past(mod_r) && $stable(sincTap_r[0]))
    else $error("bypassed stage changed the sample or moved its taps");

  chk_sinc_dc: assert property (
    sDcSettle |=> fir_r == 16'((27'sd172 * $past(mod_r)) >>> 8))
    else $error("inverse sinc dc gain is wrong");

  chk_unity_pass: assert property (
    sUnityInRange |=> dacData == $past(fir_r[13:0]))
    else $error("unity scale did not pass the sample unchanged");

  chk_scale_apply: assert property (
    clkEn && activeScale != SCALE_UNITY && !satNow
    |=> dacData == $past(scaleShift[13:0]))
    else $error("scaled sample has wrong weight");

  chk_clamp_ends: assert property (
    clkEn && satNow |=> sat_r && (dacData == DAC_MAX || dacData == DAC_MIN))
    else $error("out-of-range result was not clamped");

endmodule // quc_upconvert_datapath

// ### quc_dac_model.sv
// Behavioural model of the on-chip converter that the datapath feeds
`timescale 1ns/1ps
module quc_dac_model
  import quc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Converter word from the datapath
  input wire logic signed [13:0] dacData,
  // Level the converter is producing now
  output logic signed [13:0] dacLevel
);
  // Latch one 14-bit word on every sample clock edge, no gaps
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dacLevel <= 14'sh0000; // Mid-scale while held in reset
    end else begin
      dacLevel <= dacData;
    end
  end
endmodule // quc_dac_model

// ### testbench.sv
// Self-checking bench for the quadrature upconvert datapath
`timescale 1ns/1ps
module testbench;
  import quc_pkg::*;
  logic ref_clk = 1'b0; // Sample clock, 25 MHz
  logic resetn = 1'b0; // Async reset, active low
  logic clkEn = 1'b1; // Frozen for three edges only in tPhase
  logic [4:0] regAddr = 5'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [1:0] profileSel = 2'h0;
  logic signed [13:0] iData = 14'sh0000;
  logic signed [13:0] qData = 14'sh0000;
  logic signed [13:0] dacData;
  logic signed [13:0] dacLevel; // Word held by the converter model
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  // Half period of 20 ns
  always #20 ref_clk = ~ref_clk;

  quc_upconvert_datapath dut_u (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .profileSel(profileSel), .iData(iData), .qData(qData), .dacData(dacData));
  quc_dac_model dac_u (.ref_clk(ref_clk), .resetn(resetn), .dacData(dacData),
    .dacLevel(dacLevel));

  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
  end

  // Byte compare, case equality so unknowns fail
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  // Sample compare with a tolerance for carrier amplitude error
  task automatic cmpNear(input logic signed [13:0] got, input int exp, input int tol);
    int d;
    d = int'(got) - exp;
    tests_run++;
    if ($isunknown(got) || d > tol || d < -tol) begin
      n_fail++;
      $display("[FAIL] %0t sample %0d expected %0d", $time, got, exp);
    end
  endtask

  // Full reset, registers back to their start values
  task automatic doReset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask

  // One byte write, strobe for a single edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask

  // One byte read, answer registered one edge after the address
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    @(posedge ref_clk);
    #1 d = regRdData;
  endtask

  // Apply a constant I/Q pair and wait out carrier and pipeline latency
  task automatic setIq(input int i, input int q);
    @(posedge ref_clk);
    iData <= 14'(i);
    qData <= 14'(q);
    repeat (40) @(posedge ref_clk);
    #1;
  endtask

  // Start values of every profile
  task automatic tReset();
    logic [7:0] v;
    doReset();
    for (int p = 0; p < NPROF; p++) begin
      rd(5'(12 + 6 * p), v);
      cmp8(v, 8'hB5);
      rd(5'(8 + 6 * p), v);
      cmp8(v, 8'h00);
    end
  endtask

  // Tuning word bytes land low byte first; profile 2 low byte at 14h stays untouched
  task automatic tTuning();
    logic [7:0] v;
    logic [31:0] w;
    w = 32'h556A_AAAB; // Below 2^31 as the host must keep it
    for (int b = 0; b < 4; b++) begin
      wr(5'(8 + b), w[8*b +: 8]);
    end
    for (int b = 0; b < 4; b++) begin
      rd(5'(8 + b), v);
      cmp8(v, w[8*b +: 8]);
    end
    rd(5'h14, v);
    cmp8(v, 8'h00);
  endtask

  // Phase top byte steps by the word of the selected profile each clock
  task automatic tPhase();
    logic [7:0] a;
    logic [7:0] b;
    doReset();
    wr(5'h0B, 8'h01);
    wr(5'h11, 8'h02);
    @(posedge ref_clk);
    regAddr <= 5'h02;
    @(posedge ref_clk);
    #1 a = regRdData;
    @(posedge ref_clk);
    #1 b = regRdData;
    cmp8(b, a + 8'h01);
    @(posedge ref_clk);
    profileSel <= 2'h1;
    repeat (2) @(posedge ref_clk);
    #1 a = regRdData;
    @(posedge ref_clk);
    #1 b = regRdData;
    cmp8(b, a + 8'h02);
    // Enable low freezes phase and read data alike
    @(posedge ref_clk);
    clkEn <= 1'b0;
    #1 a = regRdData;
    repeat (3) @(posedge ref_clk);
    clkEn <= 1'b1;
    #1 b = regRdData;
    cmp8(b, a);
    @(posedge ref_clk);
    #1 b = regRdData;
    cmp8(b, a + 8'h02);
    @(posedge ref_clk);
    profileSel <= 2'h0;
    // A mid-run reset must bring a running accumulator back to zero
    doReset();
    rd(5'h02, a);
    cmp8(a, 8'h00);
  endtask

  // Quarter-turn carrier: outputs walk I, +-Q, -I, -+Q in order
  task automatic tMix(input logic inv);
    int s[8];
    int k;
    int qs;
    doReset();
    wr(5'h0C, 8'h80);
    wr(5'h07, {7'h00, inv});
    wr(5'h0B, 8'h40);
    setIq(4000, 1000);
    for (int j = 0; j < 8; j++) begin
      @(posedge ref_clk);
      #1 s[j] = int'(dacLevel);
    end
    k = 0;
    for (int j = 0; j < 4; j++) begin
      if (s[j] > 3990 && s[j] < 4010) begin
        k = j;
      end
    end
    qs = inv ? 1000 : -1000;
    cmpNear(14'(s[k]), 4000, 8);
    cmpNear(14'(s[k + 1]), qs, 8);
    cmpNear(14'(s[k + 2]), -4000, 8);
    cmpNear(14'(s[k + 3]), -qs, 8);
  endtask

  // Output scale: default, unity bypass, zero and saturation at both ends
  task automatic tScale();
    logic [7:0] v;
    doReset();
    setIq(4000, 0);
    cmpNear(dacLevel, 5656, 12);
    wr(5'h0C, 8'h80);
    setIq(4000, 0);
    cmpNear(dacLevel, 4000, 4);
    wr(5'h0C, 8'h00);
    setIq(4000, 0);
    cmpNear(dacLevel, 0, 0);
    wr(5'h0C, 8'hFF);
    setIq(8000, 0);
    cmpNear(dacLevel, 8191, 0);
    rd(5'h03, v);
    cmp8(v & 8'h01, 8'h01);
    setIq(-8000, 0);
    cmpNear(dacLevel, -8192, 0);
  endtask

  // Inverse sinc costs its dc gain; bypass passes samples unchanged
  task automatic tSinc();
    int pk;
    doReset();
    wr(5'h0C, 8'h80);
    wr(5'h01, 8'h00);
    setIq(4000, 0);
    cmpNear(dacLevel, 2687, 8);
    wr(5'h01, 8'h01);
    setIq(4000, 0);
    cmpNear(dacLevel, 4000, 4);
    // Quarter-turn carrier: edge taps cancel, so the peak gets 208/256, above dc gain
    wr(5'h01, 8'h00);
    wr(5'h0B, 8'h40);
    setIq(4000, 0);
    pk = -8192;
    for (int j = 0; j < 4; j++) begin
      @(posedge ref_clk);
      #1 pk = (int'(dacLevel) > pk) ? int'(dacLevel) : pk;
    end
    cmpNear(14'(pk), 3250, 8);
  endtask

  // Main sequence
  initial begin
    tReset();
    tTuning();
    tPhase();
    tMix(1'b1);
    tMix(1'b0);
    tScale();
    tSinc();
    wrap_up();
  end
endmodule // testbench
